// file: logic/dvam_top.sv
// Stereo digital volume with per-channel zero-run auto-mute and register port.
// Assumes samples and register strobes are synchronous to ref_clk.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module dvam_top #(
    parameter int mute_count_shift = 0
) (
    input  wire logic                                    ref_clk,
    input  wire logic                                    reset,
    input  wire logic [dvam_pkg::ADDR_WIDTH-1:0]         reg_addr,
    input  wire logic [dvam_pkg::DATA_WIDTH-1:0]         reg_wdata,
    input  wire logic                                    reg_write,
    input  wire logic                                    reg_read,
    output logic [dvam_pkg::DATA_WIDTH-1:0]              reg_rdata,
    input  wire logic                                    sample_valid,
    input  wire logic signed [dvam_pkg::SAMPLE_WIDTH-1:0] left_sample_in,
    input  wire logic signed [dvam_pkg::SAMPLE_WIDTH-1:0] right_sample_in,
    output logic                                         out_valid,
    output logic signed [dvam_pkg::SAMPLE_WIDTH-1:0]     left_sample_out,
    output logic signed [dvam_pkg::SAMPLE_WIDTH-1:0]     right_sample_out,
    output logic                                         left_auto_muted,
    output logic                                         right_auto_muted
);
    import dvam_pkg::*;

    logic [DELAY_WIDTH-1:0] left_zero_mute_delay_reg;
    logic [DELAY_WIDTH-1:0] right_zero_mute_delay_reg;
    logic [LINK_WIDTH-1:0]  volume_link_select_reg;
    logic [7:0]             left_gain_code_reg;
    logic [7:0]             right_gain_code_reg;
    logic [7:0]             reg_rdata_next;

    logic [DELAY_WIDTH-1:0]       delay_sel   [CHANNELS];
    logic [7:0]                   eff_code    [CHANNELS];
    logic signed [SAMPLE_WIDTH-1:0] chan_in   [CHANNELS];
    logic signed [SAMPLE_WIDTH-1:0] chan_out  [CHANNELS];
    logic [COUNT_WIDTH-1:0]       zero_run_reg [CHANNELS];
    logic                         muted_reg   [CHANNELS];

    // Register writes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            left_zero_mute_delay_reg  <= LEFT_DELAY_RESET;
            right_zero_mute_delay_reg <= RIGHT_DELAY_RESET;
            volume_link_select_reg    <= LINK_RESET;
            left_gain_code_reg        <= LEFT_VOLUME_RESET;
            right_gain_code_reg       <= RIGHT_VOLUME_RESET;
        end else if (reg_write) begin
            unique case (reg_addr)
                AUTO_MUTE_DELAY_OFFSET: begin
                    left_zero_mute_delay_reg  <= reg_wdata[LEFT_DELAY_LSB +: DELAY_WIDTH];
                    right_zero_mute_delay_reg <= reg_wdata[RIGHT_DELAY_LSB +: DELAY_WIDTH];
                end
                VOLUME_LINK_CONTROL_OFFSET: begin
                    volume_link_select_reg <= reg_wdata[LINK_WIDTH-1:0];
                end
                LEFT_VOLUME_OFFSET: begin
                    left_gain_code_reg <= reg_wdata;
                end
                RIGHT_VOLUME_OFFSET: begin
                    right_gain_code_reg <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; reserved bits and unmapped addresses read as zero
    always_comb begin
        reg_rdata_next = 8'h00;
        unique case (reg_addr)
            AUTO_MUTE_DELAY_OFFSET: begin
                reg_rdata_next[LEFT_DELAY_LSB +: DELAY_WIDTH]  = left_zero_mute_delay_reg;
                reg_rdata_next[RIGHT_DELAY_LSB +: DELAY_WIDTH] = right_zero_mute_delay_reg;
            end
            VOLUME_LINK_CONTROL_OFFSET: begin
                reg_rdata_next[LINK_WIDTH-1:0] = volume_link_select_reg;
            end
            LEFT_VOLUME_OFFSET: begin
                reg_rdata_next = left_gain_code_reg;
            end
            RIGHT_VOLUME_OFFSET: begin
                reg_rdata_next = right_gain_code_reg;
            end
            default: begin
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= reg_rdata_next;
        end else begin
            reg_rdata <= '0;
        end
    end

    function automatic logic [COUNT_WIDTH-1:0] zero_run_limit(input logic [2:0] sel);
        unique case (sel)
            3'h0: zero_run_limit = ZERO_RUN_0;
            3'h1: zero_run_limit = ZERO_RUN_1;
            3'h2: zero_run_limit = ZERO_RUN_2;
            3'h3: zero_run_limit = ZERO_RUN_3;
            3'h4: zero_run_limit = ZERO_RUN_4;
            3'h5: zero_run_limit = ZERO_RUN_5;
            3'h6: zero_run_limit = ZERO_RUN_6;
            3'h7: zero_run_limit = ZERO_RUN_7;
        endcase
    endfunction

    always_comb begin
        delay_sel[0] = left_zero_mute_delay_reg;
        delay_sel[1] = right_zero_mute_delay_reg;
        chan_in[0]   = left_sample_in;
        chan_in[1]   = right_sample_in;
        eff_code[0]  = left_gain_code_reg;
        // Reserved link codes fall through to independent volumes
        if (volume_link_select_reg == LINK_FOLLOW_LEFT) begin
            eff_code[1] = left_gain_code_reg;
        end else begin
            eff_code[1] = right_gain_code_reg;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic [COUNT_WIDTH-1:0] limit;
            logic                   is_zero;

            // Counted in samples, not clocks, so the delay tracks the sample rate
            assign limit   = zero_run_limit(delay_sel[ch]) >> mute_count_shift;
            assign is_zero = (chan_in[ch] == '0);

            // Counter saturates at the limit; a new, smaller limit mutes on the next zero
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    zero_run_reg[ch] <= '0;
                    muted_reg[ch]    <= 1'b0;
                end else if (sample_valid) begin
                    if (!is_zero) begin
                        zero_run_reg[ch] <= '0;
                        muted_reg[ch]    <= 1'b0;
                    end else if (zero_run_reg[ch] + 1'b1 >= limit) begin
                        zero_run_reg[ch] <= limit;
                        muted_reg[ch]    <= 1'b1;
                    end else begin
                        zero_run_reg[ch] <= zero_run_reg[ch] + 1'b1;
                    end
                end
            end

            dvam_gain u_gain (
                .ref_clk      (ref_clk),
                .reset        (reset),
                .sample_valid (sample_valid),
                .sample_in    (chan_in[ch]),
                .gain_code    (eff_code[ch]),
                .force_zero   (muted_reg[ch]),
                .sample_out   (chan_out[ch])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= sample_valid;
        end
    end

    assign left_sample_out  = chan_out[0];
    assign right_sample_out = chan_out[1];
    assign left_auto_muted  = muted_reg[0];
    assign right_auto_muted = muted_reg[1];

endmodule

// file: logic/dvam_pkg.sv
// Constants for the digital volume and zero-data auto-mute block.
// Assumes one register port with 8-bit address and data, and samples on the same clock.
package dvam_pkg;

    localparam int          SAMPLE_WIDTH    = 24;
    localparam int          ADDR_WIDTH      = 8;
    localparam int          DATA_WIDTH      = 8;
    localparam int          CHANNELS        = 2;
    localparam int          COUNT_WIDTH     = 19;

    localparam logic [7:0]  AUTO_MUTE_DELAY_OFFSET     = 8'h3b;
    localparam logic [7:0]  VOLUME_LINK_CONTROL_OFFSET = 8'h3c;
    localparam logic [7:0]  LEFT_VOLUME_OFFSET         = 8'h3d;
    localparam logic [7:0]  RIGHT_VOLUME_OFFSET        = 8'h3e;

    localparam int          LEFT_DELAY_LSB  = 4;
    localparam int          RIGHT_DELAY_LSB = 0;
    localparam int          DELAY_WIDTH     = 3;
    localparam int          LINK_WIDTH      = 2;

    localparam logic [2:0]  LEFT_DELAY_RESET  = 3'h0;
    localparam logic [2:0]  RIGHT_DELAY_RESET = 3'h0;
    localparam logic [1:0]  LINK_RESET        = 2'h0;
    localparam logic [7:0]  LEFT_VOLUME_RESET  = 8'h10;
    localparam logic [7:0]  RIGHT_VOLUME_RESET = 8'h30;

    localparam logic [1:0]  LINK_INDEPENDENT = 2'h0;
    localparam logic [1:0]  LINK_FOLLOW_LEFT = 2'h1;

    localparam logic [7:0]  GAIN_CODE_MUTE  = 8'hff;
    localparam int          STEPS_PER_OCTAVE = 12;
    // Gain shift so that code 0x30 (octave 4) lands on exactly unity
    localparam int          UNITY_OCTAVE    = 4;
    localparam int          MANT_FRAC_BITS  = 15;

    // Zero-run lengths in samples at the 96 kHz reference rate
    localparam int          REF_RATE_HZ     = 96000;
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_0 = 19'h00450;  // 11.5 ms
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_1 = 19'h013e0;  // 53 ms
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_2 = 19'h027f0;  // 106.5 ms
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_3 = 19'h063f0;  // 266.5 ms
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_4 = 19'h0c8a0;  // 0.535 s
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_5 = 19'h18f60;  // 1.065 s
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_6 = 19'h3e760;  // 2.665 s
    localparam logic [COUNT_WIDTH-1:0] ZERO_RUN_7 = 19'h7cec0;  // 5.33 s

endpackage

// file: logic/dvam_gain.sv
// One channel of gain scaling with 0.5 dB steps and output forcing to zero.
// Assumes sample_valid is a one-cycle strobe on ref_clk with sample_in alongside.
`timescale 1ns/10ps
module dvam_gain (
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic                              sample_valid,
    input  wire logic signed [dvam_pkg::SAMPLE_WIDTH-1:0] sample_in,
    input  wire logic [7:0]                        gain_code,
    input  wire logic                              force_zero,
    output logic signed [dvam_pkg::SAMPLE_WIDTH-1:0]      sample_out
);
    import dvam_pkg::*;

    localparam logic signed [47:0] SAT_MAX = 48'sh0000007fffff;
    localparam logic signed [47:0] SAT_MIN = -48'sh000000800000;

    // Twelve mantissas of 10^(-k/40) in Q15; octaves are plain shifts.
    // Trade-off: a shift is 6.02 dB, so top-of-range codes sit about 0.08 dB high.
    function automatic logic [15:0] mantissa(input logic [3:0] k);
        unique case (k)
            4'h0:    mantissa = 16'h8000;
            4'h1:    mantissa = 16'h78d7;
            4'h2:    mantissa = 16'h7215;
            4'h3:    mantissa = 16'h6bb3;
            4'h4:    mantissa = 16'h65ad;
            4'h5:    mantissa = 16'h5ffd;
            4'h6:    mantissa = 16'h5a9e;
            4'h7:    mantissa = 16'h558c;
            4'h8:    mantissa = 16'h50c3;
            4'h9:    mantissa = 16'h4c3f;
            4'ha:    mantissa = 16'h47fb;
            4'hb:    mantissa = 16'h43f4;
            default: mantissa = 16'h0000;
        endcase
    endfunction

    logic [4:0]         octave;
    logic [3:0]         step;
    logic signed [47:0] product;
    logic signed [47:0] scaled;
    logic signed [SAMPLE_WIDTH-1:0] saturated;

    always_comb begin
        octave  = 5'(gain_code / 8'(STEPS_PER_OCTAVE));
        step    = 4'(gain_code % 8'(STEPS_PER_OCTAVE));
        product = 48'(sample_in) * $signed({1'b0, mantissa(step)});
        scaled  = product >>> (MANT_FRAC_BITS - UNITY_OCTAVE + 32'(octave));
        if (scaled > SAT_MAX) begin
            saturated = SAT_MAX[SAMPLE_WIDTH-1:0];
        end else if (scaled < SAT_MIN) begin
            saturated = SAT_MIN[SAMPLE_WIDTH-1:0];
        end else begin
            saturated = scaled[SAMPLE_WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sample_out <= '0;
        end else if (sample_valid) begin
            if (force_zero || gain_code == GAIN_CODE_MUTE) begin
                sample_out <= '0;
            end else begin
                sample_out <= saturated;
            end
        end
    end

endmodule

// file: verification/dvam_sample_source.sv
// Sample source that stands in for the serial audio input of the block.
// Assumes the bench paces frames on send, one sample pair per request.
`timescale 1ns/10ps
module dvam_sample_source (
    input  wire logic                                    ref_clk,
    input  wire logic                                    reset,
    input  wire logic                                    send,
    input  wire logic signed [dvam_pkg::SAMPLE_WIDTH-1:0] send_left,
    input  wire logic signed [dvam_pkg::SAMPLE_WIDTH-1:0] send_right,
    output logic                                         sample_valid,
    output logic signed [dvam_pkg::SAMPLE_WIDTH-1:0]     left_sample_in,
    output logic signed [dvam_pkg::SAMPLE_WIDTH-1:0]     right_sample_in
);
    import dvam_pkg::*;
    // One strobe per frame at whatever rate the bench paces
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sample_valid    <= 1'b0;
            left_sample_in  <= '0;
            right_sample_in <= '0;
        end else begin
            sample_valid    <= send;
            // Lines carry no data between frames; toggle them so nothing leans on them
            left_sample_in  <= send ? send_left : ~left_sample_in;
            right_sample_in <= send ? send_right : ~right_sample_in;
        end
    end
endmodule

// file: verification/dvam_assertions.sv
// Port-level checks for the volume and zero-run mute block.
// Assumes one clock domain; attached to every dvam_top by the bind below.
`timescale 1ns/10ps
module dvam_assertions
    import dvam_pkg::*;
#(
    parameter int mute_count_shift = 0
) (
    input wire logic                              ref_clk,
    input wire logic                              reset,
    input wire logic [ADDR_WIDTH-1:0]             reg_addr,
    input wire logic [DATA_WIDTH-1:0]             reg_wdata,
    input wire logic                              reg_write,
    input wire logic                              reg_read,
    input wire logic [DATA_WIDTH-1:0]             reg_rdata,
    input wire logic                              sample_valid,
    input wire logic signed [SAMPLE_WIDTH-1:0]    left_sample_in,
    input wire logic signed [SAMPLE_WIDTH-1:0]    right_sample_in,
    input wire logic                              out_valid,
    input wire logic signed [SAMPLE_WIDTH-1:0]    left_sample_out,
    input wire logic signed [SAMPLE_WIDTH-1:0]    right_sample_out,
    input wire logic                              left_auto_muted,
    input wire logic                              right_auto_muted
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_valid_pulse: assert property (sample_valid |=> out_valid)
        else $error("no output strobe after a sample");
    a_no_extra_valid: assert property (!sample_valid |=> !out_valid)
        else $error("output strobe without a sample");
    a_output_hold: assert property (!out_valid |->
        $stable(left_sample_out) && $stable(right_sample_out))
        else $error("output sample changed without strobe");
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property (reg_read &&
        !(reg_addr inside {[8'h3b:8'h3e]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    a_volume_readback: assert property (reg_write && reg_addr == LEFT_VOLUME_OFFSET
        ##1 reg_read && reg_addr == LEFT_VOLUME_OFFSET |=> reg_rdata == $past(reg_wdata, 2))
        else $error("left volume read back differs");
    a_left_mute_zero: assert property (sample_valid && left_auto_muted
        |=> left_sample_out == '0)
        else $error("muted left channel not silent");
    a_right_mute_zero: assert property (sample_valid && right_auto_muted
        |=> right_sample_out == '0)
        else $error("muted right channel not silent");
    a_nonzero_unmutes: assert property (sample_valid && left_sample_in != '0
        |=> !left_auto_muted)
        else $error("nonzero left sample left mute set");
    a_right_nonzero_unmutes: assert property (sample_valid && right_sample_in != '0
        |=> !right_auto_muted)
        else $error("nonzero right sample left mute set");
    a_mute_on_sample: assert property (!sample_valid |=>
        $stable(left_auto_muted) && $stable(right_auto_muted))
        else $error("mute flag moved without a sample");
endmodule

bind dvam_top dvam_assertions #(.mute_count_shift(mute_count_shift)) u_chk (
    .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sample_valid, .left_sample_in, .right_sample_in, .out_valid, .left_sample_out,
    .right_sample_out, .left_auto_muted, .right_auto_muted
);

// file: verification/digital_volume_automute_tb.sv
// Self-checking bench for the volume and zero-run mute block.
// Assumes dvam_top with a shortened mute count, fed by the sample source model.
`timescale 1ns/10ps
module digital_volume_automute_tb;
    import dvam_pkg::*;
    // Mute limits shrink by 2^SH so a zero run takes a few samples
    localparam int SH = 8;
    localparam int LIM0 = 1104 >> SH;
    localparam int LIM1 = 5088 >> SH;
    // 0x31 is one half-dB step below unity: 0x100000 times the Q15 mantissa 0x78d7 comes to 0x0f1ae0
    localparam logic [7:0] GCODE [6] = '{8'h30, 8'h24, 8'h3c, 8'h0c, 8'h31, 8'hff};
    localparam logic [23:0] GPOS [6] = '{24'h100000, 24'h200000, 24'h080000,
                                         24'h7fffff, 24'h0f1ae0, 24'h000000};
    localparam logic [23:0] GNEG [6] = '{24'hf00000, 24'he00000, 24'hf80000,
                                         24'h800000, 24'hf0e520, 24'h000000};
    logic               ref_clk = 1'b0;
    logic               reset = 1'b1;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_write = 1'b0;
    logic               reg_read = 1'b0;
    logic               send = 1'b0;
    logic signed [23:0] send_left = '0;
    logic signed [23:0] send_right = '0;
    logic [7:0]         reg_rdata;
    logic               sample_valid, out_valid, left_auto_muted, right_auto_muted;
    logic signed [23:0] left_sample_in, right_sample_in, left_sample_out, right_sample_out;
    int                 bad_count = 0;
    int                 checked = 0;

    always #4 ref_clk = ~ref_clk;

    dvam_sample_source src (.ref_clk, .reset, .send, .send_left, .send_right,
        .sample_valid, .left_sample_in, .right_sample_in);
    dvam_top #(.mute_count_shift(SH)) dut (.ref_clk, .reset, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .sample_valid, .left_sample_in,
        .right_sample_in, .out_valid, .left_sample_out, .right_sample_out,
        .left_auto_muted, .right_auto_muted);

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: register %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_smp(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: sample %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    // Tasks are entered at a rising edge and return at one; all drives are NBAs there.
    // A write leaves its strobe high, so back-to-back writes never drop and raise it at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask
    // Read data stands in the cycle after the strobe; taken at the edge that closes it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(posedge ref_clk);
        chk_reg(reg_rdata, exp);
    endtask
    task automatic snd(input logic [23:0] l, r, el, er);
        reg_write <= 1'b0;
        send <= 1'b1;
        send_left <= l;
        send_right <= r;
        @(posedge ref_clk);
        send <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        chk_bit(out_valid, 1'b1);
        chk_smp(left_sample_out, el);
        chk_smp(right_sample_out, er);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        $display("Error %0t: run did not complete", $time);
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(AUTO_MUTE_DELAY_OFFSET, 8'h00);
        rd(VOLUME_LINK_CONTROL_OFFSET, 8'h00);
        rd(LEFT_VOLUME_OFFSET, 8'h10);
        rd(RIGHT_VOLUME_OFFSET, 8'h30);
        wr(AUTO_MUTE_DELAY_OFFSET, 8'hff);
        rd(AUTO_MUTE_DELAY_OFFSET, 8'h77);
        wr(VOLUME_LINK_CONTROL_OFFSET, 8'hff);
        rd(VOLUME_LINK_CONTROL_OFFSET, 8'h03);
        wr(8'h3f, 8'h55);
        rd(8'h3f, 8'h00);
        wr(LEFT_VOLUME_OFFSET, 8'ha5);
        rd(LEFT_VOLUME_OFFSET, 8'ha5);
        wr(VOLUME_LINK_CONTROL_OFFSET, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(LEFT_VOLUME_OFFSET, GCODE[i]);
            wr(RIGHT_VOLUME_OFFSET, GCODE[i]);
            snd(24'h100000, 24'hf00000, GPOS[i], GNEG[i]);
        end
        wr(LEFT_VOLUME_OFFSET, 8'h3c);
        wr(RIGHT_VOLUME_OFFSET, 8'h30);
        for (int k = 0; k < 4; k++) begin
            wr(VOLUME_LINK_CONTROL_OFFSET, 8'(k));
            snd(24'h100000, 24'h100000, 24'h080000,
                (k == 1) ? 24'h080000 : 24'h100000);
        end
        wr(VOLUME_LINK_CONTROL_OFFSET, 8'h01);
        wr(LEFT_VOLUME_OFFSET, 8'hff);
        snd(24'h100000, 24'h100000, 24'h000000, 24'h000000);
        wr(VOLUME_LINK_CONTROL_OFFSET, 8'h00);
        wr(LEFT_VOLUME_OFFSET, 8'h30);
        for (int m = 0; m < 2; m++) begin
            wr(AUTO_MUTE_DELAY_OFFSET, (m == 1) ? 8'h10 : 8'h01);
            for (int n = 1; n <= 20; n++) begin
                snd('0, '0, '0, '0);
                chk_bit(left_auto_muted, n >= ((m == 1) ? LIM1 : LIM0));
                chk_bit(right_auto_muted, n >= ((m == 1) ? LIM0 : LIM1));
            end
            snd(24'h100000, 24'h100000, '0, '0);
            chk_bit(left_auto_muted, 1'b0);
            chk_bit(right_auto_muted, 1'b0);
            snd(24'h100000, 24'h100000, 24'h100000, 24'h100000);
        end
        tally_and_finish();
    end
endmodule
